//--- design/fpm_pkg.sv
// Constants, types and encodings of the front-panel menu controller.
// Assumes a single 250 MHz clock domain.
//
// What this block does
// [RULE1] Clockwise detent in navigation selects next item, down first, then right.
// [RULE2] Counter-clockwise detent selects previous item, up first, then left.
// [RULE3] Stepping past the last item wraps to the first item.
// [RULE4] The selected item is shown with an arrow after its text.
// [RULE5] Short press enters edit mode; the edited value blinks.
// [RULE6] In edit mode rotation steps the value through its allowed choices.
// [RULE7] Half a second idle after a step in edit mode applies the value, editing continues.
// [RULE8] Second short press applies the value and returns to navigation.
// [RULE9] Five seconds idle in edit applies the value and returns to navigation.
// [RULE10] Under host control all knob rotation and presses are ignored.
// [RULE11] Settings of all four transmitter channels are shown and changeable.
// [RULE12] Span sits on the top line, coupling and filter on the bottom.
// [RULE13] Span offers nine ordered choices from 0.2 V to 100 V.
// [RULE14] Coupling and filter offers five choices, each but ground mapped to both settings.
// [RULE15] Ground choice keeps the filter setting previously in effect.
// [RULE16] Short press while a message shows dismisses it back to the menu.
// [RULE17] Firmware version shows for the first three seconds after power-on.
// [RULE18] Each warning starts an alarm that stops when acknowledged.
// [RULE19] Knob inputs are synchronised and debounced before decoding.
// [RULE20] Each applied setting is sent as a command to its channel.
package fpm_pkg;

  // ----------------------------------------
  // Timing.
  // ----------------------------------------
  localparam int CLK_KHZ  = 250000;
  localparam int BOOT_MS  = 3000;
  localparam int HALF_MS  = 500;
  localparam int IDLE_MS  = 5000;
  localparam int DEB_MS   = 1;
  localparam int BOOT_CYC = BOOT_MS * CLK_KHZ;
  localparam int HALF_CYC = HALF_MS * CLK_KHZ;
  localparam int IDLE_CYC = IDLE_MS * CLK_KHZ;
  localparam int DEB_CYC  = DEB_MS * CLK_KHZ;

  // ----------------------------------------
  // Sizes and reset values.
  // ----------------------------------------
  localparam int         N_CHAN   = 4;
  localparam logic [3:0] N_SPAN   = 4'h9;
  localparam logic [3:0] SPAN_RST = 4'h8;

  // ----------------------------------------
  // Types.
  // ----------------------------------------
  // Span codes 0..8 stand for 0.2,0.4,1,2,4,10,20,40,100 V spans.
  typedef logic [3:0] fpm_span_t;

  typedef enum logic [2:0] {
    DC_WIDEBAND_CHOICE,
    DC_FILTERED_CHOICE,
    AC_WIDEBAND_CHOICE,
    AC_FILTERED_CHOICE,
    GROUND_CHOICE
  } fpm_cf_t;

  typedef enum logic [1:0] {CPL_DC, CPL_AC, CPL_GND} fpm_cpl_t;
  typedef enum {VIEW_VER, VIEW_MENU, VIEW_WARN} fpm_view_mode_t;
  typedef enum {ST_NAV, ST_EDIT} fpm_state_t;

  typedef struct packed {
    fpm_span_t span;
    fpm_cf_t   cf;
    logic      filt;
  } fpm_set_t;

  typedef struct packed {
    logic [1:0] chan;
    fpm_span_t  span;
    fpm_cpl_t   cpl;
    logic       filt;
  } fpm_cmd_t;

  typedef struct packed {
    logic       show_ver;
    logic       show_warn;
    logic [2:0] item;
    logic       blink;
    logic [3:0] edit_val;
  } fpm_view_t;

endpackage

//--- design/fpm_menu.sv
// Front-panel menu controller: knob decoding, menu, edit and messages.
// Assumes knob pins are asynchronous and host/warning inputs share CLK.
`timescale 1ns/100ps
module fpm_menu
  import fpm_pkg::*;
#(
  parameter int BOOT_C = BOOT_CYC,
  parameter int HALF_C = HALF_CYC,
  parameter int IDLE_C = IDLE_CYC,
  parameter int DEB_C  = DEB_CYC
) (
  // Clock and reset.
  input  wire logic     CLK,
  input  wire logic     ARST_N,
  // Knob pins, high when asserted.
  input  wire logic     KNOB_A,
  input  wire logic     KNOB_B,
  input  wire logic     KNOB_PUSH,
  // System inputs.
  input  wire logic     HOST_CTRL,
  input  wire logic     WARN_EVENT,
  // Display contents.
  output fpm_view_t     VIEW,
  output fpm_set_t [3:0] CH_SET,
  output logic          ALARM,
  // Command link.
  output fpm_cmd_t      CMD,
  output logic          CMD_VALID
);

  // ----------------------------------------
  // Declarations.
  // ----------------------------------------
  logic [2:0]  raw;
  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [2:0]  stb_q;
  logic [17:0] deb_q [3];
  logic        a_prev_q;
  logic        p_prev_q;
  logic        ev_cw;
  logic        ev_ccw;
  logic        ev_press;
  logic        menu_on;
  fpm_view_mode_t view_q;
  fpm_state_t  state_q;
  logic [30:0] boot_q;
  logic [30:0] idle_q;
  logic        dirty_q;
  logic [2:0]  item_q;
  logic [3:0]  val_q;
  logic        alarm_q;
  fpm_set_t [3:0] set_q;
  fpm_cmd_t    cmd_q;
  logic        cmd_v_q;
  logic        half_hit;
  logic        idle_hit;
  logic        apply;
  logic [1:0]  chan;
  logic        cf_row;
  logic [3:0]  lim;

  assign raw = {KNOB_PUSH, KNOB_B, KNOB_A};

  // ----------------------------------------
  // Input conditioning.
  // ----------------------------------------
  // Two flops, then a counter that accepts a level held for DEB_C cycles.
  for (genvar i = 0; i < 3; i++) begin : g_in
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
        stb_q[i]   <= 1'b0;
        deb_q[i]   <= 18'h0;
      end else begin
        sync1_q[i] <= raw[i];
        sync2_q[i] <= sync1_q[i];                   // RULE19
        if (sync2_q[i] == stb_q[i]) begin
          deb_q[i] <= 18'h0;
        end else if (deb_q[i] == 18'(DEB_C - 1)) begin
          stb_q[i] <= sync2_q[i];                   // RULE19
          deb_q[i] <= 18'h0;
        end else begin
          deb_q[i] <= deb_q[i] + 18'h1;
        end
      end
    end
  end

  // Edge history of the clean phase A and push levels.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_prev_q <= 1'b0;
      p_prev_q <= 1'b0;
    end else begin
      a_prev_q <= stb_q[0];
      p_prev_q <= stb_q[2];
    end
  end

  // A rising on phase A is one detent; phase B gives its direction.
  // Host control masks every knob event.
  assign ev_cw    = stb_q[0] & ~a_prev_q & ~stb_q[1] & ~HOST_CTRL; // RULE10
  assign ev_ccw   = stb_q[0] & ~a_prev_q & stb_q[1] & ~HOST_CTRL;  // RULE10
  assign ev_press = stb_q[2] & ~p_prev_q & ~HOST_CTRL;             // RULE10
  assign menu_on  = (view_q == VIEW_MENU);

  // ----------------------------------------
  // Message views and alarm.
  // ----------------------------------------
  // Version first, then the menu; a warning takes over until pressed away.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      view_q <= VIEW_VER;
    end else if (WARN_EVENT) begin
      view_q <= VIEW_WARN;
    end else if (!menu_on && ev_press) begin
      view_q <= VIEW_MENU;                          // RULE16
    end else if (view_q == VIEW_VER && boot_q == 31'(BOOT_C - 1)) begin
      view_q <= VIEW_MENU;                          // RULE17
    end
  end

  // Power-on display timer; stops once it has expired.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot_q <= 31'h0;
    end else if (boot_q != 31'(BOOT_C - 1)) begin
      boot_q <= boot_q + 31'h1;                     // RULE17
    end
  end

  // The alarm is set by a warning and cleared by its dismissal; set wins.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alarm_q <= 1'b0;
    end else if (WARN_EVENT) begin
      alarm_q <= 1'b1;                              // RULE18
    end else if (view_q == VIEW_WARN && ev_press) begin
      alarm_q <= 1'b0;                              // RULE18
    end
  end

  // ----------------------------------------
  // Navigation and edit.
  // ----------------------------------------
  // Item bits: [2:1] channel column, [0] row (0 span, 1 coupling).
  assign chan     = item_q[2:1];
  assign cf_row   = item_q[0];
  assign lim      = cf_row ? 4'h5 : N_SPAN;          // RULE13 RULE14
  assign half_hit = dirty_q && idle_q == 31'(HALF_C - 1);
  assign idle_hit = idle_q == 31'(IDLE_C - 1);
  assign apply    = state_q == ST_EDIT && ((menu_on && ev_press) || half_hit || idle_hit);

  // Mode control.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_NAV;
    end else begin
      case (state_q)
        ST_NAV: begin
          if (menu_on && ev_press) begin
            state_q <= ST_EDIT;                     // RULE5
          end
        end
        ST_EDIT: begin
          if ((menu_on && ev_press) || idle_hit) begin
            state_q <= ST_NAV;                      // RULE8 RULE9
          end
        end
        default: state_q <= ST_NAV;
      endcase
    end
  end

  // Selection moves one item per detent; the 3-bit index wraps itself.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      item_q <= 3'h0;
    end else if (state_q == ST_NAV && menu_on) begin
      if (ev_cw) begin
        item_q <= item_q + 3'h1;                    // RULE1 RULE3
      end else if (ev_ccw) begin
        item_q <= item_q - 3'h1;                    // RULE2 RULE3
      end
    end
  end

  // Edited value: loaded on entry, stepped with wrap inside its choices.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      val_q <= 4'h0;
    end else if (state_q == ST_NAV && menu_on && ev_press) begin
      val_q <= cf_row ? {1'b0, set_q[chan].cf} : set_q[chan].span;
    end else if (state_q == ST_EDIT && menu_on) begin
      if (ev_cw) begin
        val_q <= (val_q == lim - 4'h1) ? 4'h0 : val_q + 4'h1;  // RULE6
      end else if (ev_ccw) begin
        val_q <= (val_q == 4'h0) ? lim - 4'h1 : val_q - 4'h1;  // RULE6
      end
    end
  end

  // Idle timer restarts on any knob event; dirty marks an unapplied step.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idle_q  <= 31'h0;
      dirty_q <= 1'b0;
    end else if (state_q != ST_EDIT || ev_cw || ev_ccw || ev_press) begin
      idle_q  <= 31'h0;
      dirty_q <= state_q == ST_EDIT && (ev_cw || ev_ccw);
    end else begin
      if (!idle_hit) begin
        idle_q <= idle_q + 31'h1;                   // RULE9
      end
      if (half_hit) begin
        dirty_q <= 1'b0;                            // RULE7
      end
    end
  end

  // ----------------------------------------
  // Applied settings and command link.
  // ----------------------------------------
  // Each channel keeps its span, choice and filter.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int c = 0; c < N_CHAN; c++) begin
        set_q[c] <= '{span: SPAN_RST, cf: DC_WIDEBAND_CHOICE, filt: 1'b0};
      end
    end else if (apply) begin
      if (!cf_row) begin
        set_q[chan].span <= val_q;                  // RULE13
      end else begin
        set_q[chan].cf <= fpm_cf_t'(val_q[2:0]);    // RULE14
        if (val_q[2:0] != 3'(GROUND_CHOICE)) begin
          set_q[chan].filt <= val_q[2:0] == 3'(DC_FILTERED_CHOICE)
                           || val_q[2:0] == 3'(AC_FILTERED_CHOICE); // RULE15
        end
      end
    end
  end

  // One command per apply, carrying the channel's full new setting.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_v_q <= 1'b0;
      cmd_q   <= '0;
    end else begin
      cmd_v_q <= apply;                             // RULE20
      if (apply) begin
        cmd_q.chan <= chan;
        cmd_q.span <= cf_row ? set_q[chan].span : val_q;
        if (!cf_row) begin
          cmd_q.cpl  <= set_q[chan].cf == GROUND_CHOICE ? CPL_GND :
                        set_q[chan].cf >= AC_WIDEBAND_CHOICE ? CPL_AC : CPL_DC;
          cmd_q.filt <= set_q[chan].filt;
        end else begin
          cmd_q.cpl  <= val_q[2:0] == 3'(GROUND_CHOICE) ? CPL_GND :
                        val_q[2:0] >= 3'(AC_WIDEBAND_CHOICE) ? CPL_AC : CPL_DC;
          cmd_q.filt <= val_q[2:0] == 3'(GROUND_CHOICE) ? set_q[chan].filt :
                        val_q[2:0] == 3'(DC_FILTERED_CHOICE)
                        || val_q[2:0] == 3'(AC_FILTERED_CHOICE);        // RULE15
        end
      end
    end
  end

  // Display view: arrow position, blink, and the value being edited.
  assign VIEW.show_ver  = view_q == VIEW_VER;       // RULE17
  assign VIEW.show_warn = view_q == VIEW_WARN;
  assign VIEW.item      = item_q;                   // RULE4 RULE12
  assign VIEW.blink     = state_q == ST_EDIT;       // RULE5
  assign VIEW.edit_val  = val_q;
  assign CH_SET         = set_q;                    // RULE11
  assign ALARM          = alarm_q;
  assign CMD            = cmd_q;
  assign CMD_VALID      = cmd_v_q;

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  logic nav_on;
  assign nav_on = state_q == ST_NAV && menu_on;

  a_cw_step: assert property (nav_on && ev_cw |=> item_q == $past(item_q) + 3'h1) // RULE1
    else $error("Clockwise step did not advance the selection.");
  a_ccw_step: assert property (nav_on && ev_ccw |=> item_q == $past(item_q) - 3'h1) // RULE2
    else $error("Counter-clockwise step did not move the selection back.");
  a_wrap_first: assert property (nav_on && ev_cw && item_q == 3'h7 |=> item_q == 3'h0) // RULE3
    else $error("Selection did not wrap to the first item.");
  a_press_edit: assert property (nav_on && ev_press |=> VIEW.blink ##0 !CMD_VALID) // RULE5
    else $error("Press did not enter edit mode.");
  a_half_apply: assert property (
      state_q == ST_EDIT && half_hit && !idle_hit && !ev_press
      |=> CMD_VALID && state_q == ST_EDIT)          // RULE7
    else $error("Half-second idle did not apply while staying in edit.");
  a_press_leave: assert property (state_q == ST_EDIT && menu_on && ev_press
      |=> CMD_VALID && state_q == ST_NAV)           // RULE8
    else $error("Second press did not apply and leave edit mode.");
  a_idle_leave: assert property (state_q == ST_EDIT && idle_hit
      |=> CMD_VALID && state_q == ST_NAV)           // RULE9
    else $error("Idle timeout did not return to navigation.");
  a_host_ignore: assert property (HOST_CTRL |=> $stable(item_q) && $stable(val_q)) // RULE10
    else $error("Knob acted while the host had control.");
  a_boot_ver: assert property (VIEW.show_ver && !WARN_EVENT && !ev_press
      |-> boot_q < 31'(BOOT_C))                     // RULE17
    else $error("Version view outlived the power-on time.");
  a_alarm_warn: assert property (WARN_EVENT |=> ALARM && VIEW.show_warn [*2]) // RULE18
    else $error("Warning did not raise the alarm.");

  c_edit_apply: cover property (nav_on && ev_press ##[1:1000] CMD_VALID);
  c_wrap: cover property (nav_on && ev_cw && item_q == 3'h7);
  c_dismiss: cover property (VIEW.show_warn && ev_press);

endmodule

//--- verification/fpm_knob_op.sv
// Operator model: turns the knob by detents and presses it briefly.
// Assumes the caller holds off between gestures; pins change at falling edges.
`timescale 1ns/100ps
module fpm_knob_op #(
  parameter int HOLD = 12
) (
  // Clock.
  input  wire logic CLK,
  // Knob pins, high when asserted.
  output logic      KNOB_A,
  output logic      KNOB_B,
  output logic      KNOB_PUSH
);
  // ----------------------------------------
  // Pin levels at rest.
  // ----------------------------------------
  // A real knob rests with both phases and the switch open.
  initial begin
    KNOB_A    = 1'b0;
    KNOB_B    = 1'b0;
    KNOB_PUSH = 1'b0;
  end

  // Each level stands long enough to pass the debounce filter.
  task automatic hold_for();
    repeat (HOLD) @(negedge CLK);
  endtask

  // One detent: B settles first, then A rises and falls with B steady.
  task automatic turn(input logic cw);
    @(negedge CLK);
    KNOB_B = ~cw;
    hold_for();
    KNOB_A = 1'b1;
    hold_for();
    KNOB_A = 1'b0;
    hold_for();
  endtask

  // One brief press and release.
  task automatic push();
    @(negedge CLK);
    KNOB_PUSH = 1'b1;
    hold_for();
    KNOB_PUSH = 1'b0;
    hold_for();
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench of the front-panel menu controller.
// Assumes short timer parameters; the operator model drives the knob pins.
`timescale 1ns/100ps
module tb_top;
  import fpm_pkg::*;
  localparam int BOOT_T = 200;
  localparam int HALF_T = 50;
  localparam int IDLE_T = 300;
  localparam int DEB_T  = 4;

  logic           clk;
  logic           arst_n;
  logic           knob_a;
  logic           knob_b;
  logic           knob_push;
  logic           host_ctrl;
  logic           warn_event;
  fpm_view_t      view;
  fpm_set_t [3:0] ch_set;
  logic           alarm;
  fpm_cmd_t       cmd;
  logic           cmd_valid;
  int             fail_count;
  int             compares;
  int             n_cmd;
  fpm_cmd_t       last_cmd;

  fpm_menu #(
    .BOOT_C (BOOT_T),
    .HALF_C (HALF_T),
    .IDLE_C (IDLE_T),
    .DEB_C  (DEB_T)
  ) uut (
    .CLK        (clk),
    .ARST_N     (arst_n),
    .KNOB_A     (knob_a),
    .KNOB_B     (knob_b),
    .KNOB_PUSH  (knob_push),
    .HOST_CTRL  (host_ctrl),
    .WARN_EVENT (warn_event),
    .VIEW       (view),
    .CH_SET     (ch_set),
    .ALARM      (alarm),
    .CMD        (cmd),
    .CMD_VALID  (cmd_valid)
  );

  fpm_knob_op #(
    .HOLD (DEB_T + 8)
  ) op (
    .CLK       (clk),
    .KNOB_A    (knob_a),
    .KNOB_B    (knob_b),
    .KNOB_PUSH (knob_push)
  );

  // ----------------------------------------
  // Clock and command monitor.
  // ----------------------------------------
  // The clock runs at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Each command pulse is counted mid-cycle, where it stands settled.
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd;
    end
  end

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Waits for the blink to stop, within a bound.
  task automatic wait_no_blink(input int lim);
    int n;
    n = 0;
    while (view.blink !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk(1'b0, "edit mode never ended");
        finish_test();
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_reset();
    chk(view.show_ver === 1'b1 && alarm === 1'b0 && cmd_valid === 1'b0, "reset view");
    for (int i = 0; i < N_CHAN; i++) begin
      chk(ch_set[i].span === SPAN_RST && ch_set[i].cf === DC_WIDEBAND_CHOICE, "reset set");
      chk(ch_set[i].filt === 1'b0, "reset filter");
    end
  endtask

  task automatic t_boot();
    int n;
    n = 0;
    while (view.show_ver !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > BOOT_T + 20) begin
        chk(1'b0, "version view never ended");
        finish_test();
      end
    end
    chk(n >= BOOT_T - 5 && n <= BOOT_T + 5, "version view time");
  endtask

  task automatic t_nav();
    op.turn(1'b1);
    chk(view.item === 3'h1, "cw step");
    op.turn(1'b0);
    chk(view.item === 3'h0, "ccw step");
    op.turn(1'b0);
    chk(view.item === 3'h7, "ccw wrap");
    op.turn(1'b1);
    chk(view.item === 3'h0, "cw wrap to first");
  endtask

  task automatic t_edit();
    int c;
    op.push();
    chk(view.blink === 1'b1 && view.edit_val === 4'h8, "edit entry");
    op.turn(1'b1);
    chk(view.edit_val === 4'h0, "span wrap to 0.2 V");
    c = n_cmd;
    op.push();
    chk(n_cmd == c + 1 && last_cmd.chan === 2'h0 && last_cmd.span === 4'h0, "apply");
    chk(ch_set[0].span === 4'h0 && view.blink === 1'b0, "applied, nav");
    op.turn(1'b1);
    op.turn(1'b1);
    op.push();
    op.turn(1'b0);
    repeat (40) @(negedge clk);
    chk(n_cmd == c + 2 && view.blink === 1'b1, "half-second apply");
    chk(last_cmd.chan === 2'h1 && last_cmd.span === 4'h7, "channel 1 span");
    wait_no_blink(IDLE_T + 20);
    // The command pulse leaves edit mode in the same cycle; let the monitor count it.
    repeat (2) @(negedge clk);
    chk(n_cmd == c + 3 && ch_set[1].span === 4'h7, "idle apply and leave");
  endtask

  task automatic t_cf();
    fpm_cpl_t ecpl[5];
    logic     ef[5];
    ecpl = '{CPL_DC, CPL_AC, CPL_AC, CPL_GND, CPL_DC};
    ef   = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    op.turn(1'b1);
    for (int k = 0; k < 5; k++) begin
      op.push();
      op.turn(1'b1);
      op.push();
      chk(last_cmd.cpl === ecpl[k] && last_cmd.filt === ef[k], "choice map");
      chk(ch_set[1].cf === fpm_cf_t'((k + 1) % 5) && ch_set[1].filt === ef[k], "choice stored");
    end
  endtask

  task automatic t_host();
    logic [2:0] it;
    it = view.item;
    host_ctrl = 1'b1;
    op.turn(1'b1);
    op.push();
    chk(view.item === it && view.blink === 1'b0, "knob under host");
    host_ctrl = 1'b0;
  endtask

  task automatic t_warn();
    logic [2:0] it;
    it = view.item;
    warn_event = 1'b1;
    @(negedge clk);
    warn_event = 1'b0;
    @(negedge clk);
    chk(alarm === 1'b1 && view.show_warn === 1'b1, "warning raised");
    op.turn(1'b1);
    chk(view.item === it, "rotation in message");
    op.push();
    chk(alarm === 1'b0 && view.show_warn === 1'b0 && view.blink === 1'b0, "dismiss");
  endtask

  // A second reset in mid-run, then a press cuts the version view short.
  task automatic t_ver_press();
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(view.show_ver === 1'b1 && ch_set[0].span === SPAN_RST, "second reset");
    arst_n = 1'b1;
    op.push();
    chk(view.show_ver === 1'b0 && view.blink === 1'b0, "version dismissed");
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    arst_n     = 1'b0;
    host_ctrl  = 1'b0;
    warn_event = 1'b0;
    fail_count = 0;
    compares   = 0;
    n_cmd      = 0;
    repeat (20) @(negedge clk);
    t_reset();
    arst_n = 1'b1;
    t_boot();
    t_nav();
    t_edit();
    t_cf();
    t_host();
    t_warn();
    t_ver_press();
    finish_test();
  end
endmodule
